// ===== rtl/gcs_cfg.svh
// Purpose: Constants for the pin clock select and PLL factor block.
// Assumes: 8-bit register port, 3-bit selector codes.
// Notes: Definitions only.
`ifndef GCS_CFG_SVH
`define GCS_CFG_SVH
// Register offsets
`define GCS_ADDR_DSP_DAC 8'h10
`define GCS_ADDR_CP_OSR 8'h11
`define GCS_ADDR_PLL_REF 8'h12
`define GCS_ADDR_PRE_DIV 8'h14
`define GCS_ADDR_INT_MULT 8'h15
// Writable bit masks, reserved bits read zero
`define GCS_MASK_SEL_PAIR 8'h77
`define GCS_MASK_REF 8'h07
`define GCS_MASK_PRE_DIV 8'h0F
`define GCS_MASK_INT_MULT 8'h3F
// Reset values
`define GCS_RST_SEL 8'h00
`define GCS_RST_PRE_DIV 8'h00
`define GCS_RST_INT_MULT 8'h08
`define GCS_RST_RDATA 8'h00
// Field positions
`define GCS_FLD_HI 6:4
`define GCS_FLD_LO 2:0
`define GCS_FLD_PRE_DIV 3:0
`define GCS_FLD_INT_MULT 5:0
// Selector codes
`define GCS_CODE_PIN_ZERO 3'h3
`define GCS_CODE_PIN_TWO 3'h5
`define GCS_CODE_RESERVED 3'h2
`define GCS_SRC_PIN_DSP_DAC 3'h5
`define GCS_SRC_PIN_CP_OSR 3'h6
`define GCS_SRC_PIN_PLL_REF 3'h3
// Factors used while automatic clock setup owns the PLL; GCS_ONE_5B is the plus-one field offset used in both modes
`define GCS_AUTO_PRE_DIV 4'h0
`define GCS_AUTO_INT_MULT 6'h08
`define GCS_AUTO_R_MULT 4'h0
`define GCS_ONE_5B 5'h01
`endif

// ===== rtl/gcs_pkg.sv
// Purpose: Types for the pin clock select and PLL factor block.
// Assumes: Nothing beyond SystemVerilog packed structs.
// Notes: Constants live in gcs_cfg.svh.
package gcs_pkg;
  typedef struct packed {
    logic dsp;
    logic dac;
    logic cp;
    logic osr;
    logic pll_ref;
  } gcs_route_t;

  typedef struct packed {
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } gcs_reg_req_t;

  typedef struct packed {
    logic [4:0] pre_div;
    logic [5:0] int_mult;
    logic [4:0] r_mult;
    logic [10:0] mult_total;
  } gcs_pll_t;
endpackage

// ===== rtl/gcs_pin_sync.sv
// Purpose: Three-stage synchroniser with agreement filter for a pin input.
// Assumes: Pin is asynchronous to clk_i.
// Notes: Stage one feeds only stage two.
`timescale 1ns/1ps
module gcs_pin_sync (
  input wire logic clk_i,     // System clock
  input wire logic reset_i,   // Async reset, active high
  input wire logic pin_i,     // Raw pin level
  output logic level_o        // Filtered level
);
  logic s1_ff, s2_ff, s3_ff, level_ff;
  logic nxt_level;

  always_comb begin
    // Accept a change only once the two later stages agree
    nxt_level = (s2_ff == s3_ff) ? s3_ff : level_ff;
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      s1_ff <= 1'b0;
      s2_ff <= 1'b0;
      s3_ff <= 1'b0;
      level_ff <= 1'b0;
    end else begin
      s1_ff <= pin_i;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      level_ff <= nxt_level;
    end
  end

  assign level_o = level_ff;
endmodule

// ===== rtl/gcs_top.sv
// Purpose: Pin clock selection for internal dividers and PLL P/J factor registers.
// Assumes: Pin clocks are far slower than clk_i; source selectors come from outside.
// Notes: Routed pin clocks are resampled, so they carry up to five cycles of latency.
`timescale 1ns/1ps
`include "gcs_cfg.svh"
module gcs_top
  import gcs_pkg::*;
(
  input wire logic clk_i,                        // System clock, 100 MHz
  input wire logic reset_i,                      // Async reset, active high
  input wire gcs_reg_req_t reg_req_i,            // Register write port
  input wire logic [7:0] reg_rd_addr_i,          // Register read address
  output logic [7:0] reg_rdata_o,                // Read data, one cycle after address
  input wire logic [2:0] dsp_src_sel_i,          // DSP divider source selector
  input wire logic [2:0] dac_src_sel_i,          // DAC divider source selector
  input wire logic [2:0] cp_src_sel_i,           // Charge-pump divider source selector
  input wire logic [2:0] osr_src_sel_i,          // Oversampling divider source selector
  input wire logic [2:0] pll_ref_source_sel_i,   // PLL reference source selector
  input wire logic [3:0] pll_r_mult_i,           // PLL R field
  input wire logic auto_clk_set_i,               // Automatic clock setup active
  input wire logic general_pin_zero_i,           // Pin zero, asynchronous
  input wire logic general_pin_two_i,            // Pin two, asynchronous
  output gcs_route_t pin_clk_o,                  // Routed pin clock per consumer
  output gcs_route_t pin_active_o,               // Pin path live per consumer
  output gcs_pll_t pll_cfg_o                     // Effective PLL factors
);
  ////////////////////////////////////////////////////////////////////////////
  logic pin_zero, pin_two;
  logic [7:0] sel_dsp_dac_ff, sel_cp_osr_ff, sel_ref_ff, pre_div_ff, int_mult_ff, rdata_ff;
  logic [7:0] nxt_sel_dsp_dac, nxt_sel_cp_osr, nxt_sel_ref, nxt_pre_div, nxt_int_mult, nxt_rdata;
  gcs_route_t clk_ff, act_ff, nxt_clk, nxt_act;
  gcs_pll_t pll_ff, nxt_pll;

  gcs_pin_sync u_sync_zero (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .pin_i(general_pin_zero_i),
    .level_o(pin_zero)
  );

  gcs_pin_sync u_sync_two (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .pin_i(general_pin_two_i),
    .level_o(pin_two)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Register file
  always_comb begin
    nxt_sel_dsp_dac = sel_dsp_dac_ff;
    nxt_sel_cp_osr = sel_cp_osr_ff;
    nxt_sel_ref = sel_ref_ff;
    nxt_pre_div = pre_div_ff;
    nxt_int_mult = int_mult_ff;
    if (reg_req_i.wr) begin
      case (reg_req_i.addr)
        `GCS_ADDR_DSP_DAC: nxt_sel_dsp_dac = reg_req_i.wdata & `GCS_MASK_SEL_PAIR;
        `GCS_ADDR_CP_OSR: nxt_sel_cp_osr = reg_req_i.wdata & `GCS_MASK_SEL_PAIR;
        `GCS_ADDR_PLL_REF: nxt_sel_ref = reg_req_i.wdata & `GCS_MASK_REF;
        `GCS_ADDR_PRE_DIV: nxt_pre_div = reg_req_i.wdata & `GCS_MASK_PRE_DIV;
        `GCS_ADDR_INT_MULT: nxt_int_mult = reg_req_i.wdata & `GCS_MASK_INT_MULT;
        default: ;
      endcase
    end
    case (reg_rd_addr_i)
      `GCS_ADDR_DSP_DAC: nxt_rdata = sel_dsp_dac_ff;
      `GCS_ADDR_CP_OSR: nxt_rdata = sel_cp_osr_ff;
      `GCS_ADDR_PLL_REF: nxt_rdata = sel_ref_ff;
      `GCS_ADDR_PRE_DIV: nxt_rdata = pre_div_ff;
      `GCS_ADDR_INT_MULT: nxt_rdata = int_mult_ff;
      default: nxt_rdata = `GCS_RST_RDATA;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin routing: bit 1 is live, bit 0 is the routed level
  function automatic logic [1:0] route(input logic src_is_pin, input logic [2:0] code,
                                       input logic p0, input logic p2);
    logic [1:0] r;
    r = 2'h0;
    if (src_is_pin && code == `GCS_CODE_PIN_ZERO) begin
      r = {1'b1, p0};
    end else if (src_is_pin && code == `GCS_CODE_PIN_TWO) begin
      r = {1'b1, p2};
    end
    return r;
  endfunction

  always_comb begin
    {nxt_act.dsp, nxt_clk.dsp} = route(dsp_src_sel_i == `GCS_SRC_PIN_DSP_DAC,
                                       sel_dsp_dac_ff[`GCS_FLD_HI], pin_zero, pin_two);
    {nxt_act.dac, nxt_clk.dac} = route(dac_src_sel_i == `GCS_SRC_PIN_DSP_DAC,
                                       sel_dsp_dac_ff[`GCS_FLD_LO], pin_zero, pin_two);
    {nxt_act.cp, nxt_clk.cp} = route(cp_src_sel_i == `GCS_SRC_PIN_CP_OSR,
                                     sel_cp_osr_ff[`GCS_FLD_HI], pin_zero, pin_two);
    {nxt_act.osr, nxt_clk.osr} = route(osr_src_sel_i == `GCS_SRC_PIN_CP_OSR,
                                       sel_cp_osr_ff[`GCS_FLD_LO], pin_zero, pin_two);
    {nxt_act.pll_ref, nxt_clk.pll_ref} = route(pll_ref_source_sel_i == `GCS_SRC_PIN_PLL_REF,
                                               sel_ref_ff[`GCS_FLD_LO], pin_zero, pin_two);
  end

  ////////////////////////////////////////////////////////////////////////////
  // PLL factors; auto mode owns P, J and R
  always_comb begin
    if (auto_clk_set_i) begin
      nxt_pll.pre_div = `GCS_ONE_5B + {1'b0, `GCS_AUTO_PRE_DIV};
      nxt_pll.int_mult = `GCS_AUTO_INT_MULT;
      nxt_pll.r_mult = `GCS_ONE_5B + {1'b0, `GCS_AUTO_R_MULT};
    end else begin
      nxt_pll.pre_div = `GCS_ONE_5B + {1'b0, pre_div_ff[`GCS_FLD_PRE_DIV]};
      nxt_pll.int_mult = int_mult_ff[`GCS_FLD_INT_MULT];
      nxt_pll.r_mult = `GCS_ONE_5B + {1'b0, pll_r_mult_i};
    end
    // Fraction D is outside this block, so only the integer ratio is given
    nxt_pll.mult_total = 11'(nxt_pll.int_mult * nxt_pll.r_mult);
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      sel_dsp_dac_ff <= `GCS_RST_SEL;
      sel_cp_osr_ff <= `GCS_RST_SEL;
      sel_ref_ff <= `GCS_RST_SEL;
      pre_div_ff <= `GCS_RST_PRE_DIV;
      int_mult_ff <= `GCS_RST_INT_MULT;
      rdata_ff <= `GCS_RST_RDATA;
      clk_ff <= '0;
      act_ff <= '0;
      pll_ff <= '0;
    end else begin
      sel_dsp_dac_ff <= nxt_sel_dsp_dac;
      sel_cp_osr_ff <= nxt_sel_cp_osr;
      sel_ref_ff <= nxt_sel_ref;
      pre_div_ff <= nxt_pre_div;
      int_mult_ff <= nxt_int_mult;
      rdata_ff <= nxt_rdata;
      clk_ff <= nxt_clk;
      act_ff <= nxt_act;
      pll_ff <= nxt_pll;
    end
  end

  assign reg_rdata_o = rdata_ff;
  assign pin_clk_o = clk_ff;
  assign pin_active_o = act_ff;
  assign pll_cfg_o = pll_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  // Routing checks compare with the filtered pin level one cycle back
  AST_DSP_PIN_ZERO: assert property (
    (dsp_src_sel_i == `GCS_SRC_PIN_DSP_DAC && sel_dsp_dac_ff[`GCS_FLD_HI] == `GCS_CODE_PIN_ZERO)
      |=> (pin_active_o.dsp && pin_clk_o.dsp == $past(pin_zero)))
    else $error("DSP pin zero not routed");
  AST_DSP_MUTE: assert property (
    (sel_dsp_dac_ff[`GCS_FLD_HI] != `GCS_CODE_PIN_ZERO && sel_dsp_dac_ff[`GCS_FLD_HI] != `GCS_CODE_PIN_TWO)
      |=> (!pin_active_o.dsp && !pin_clk_o.dsp))
    else $error("DSP pin path not muted");
  AST_DAC_PIN_ZERO: assert property (
    (dac_src_sel_i == `GCS_SRC_PIN_DSP_DAC && sel_dsp_dac_ff[`GCS_FLD_LO] == `GCS_CODE_PIN_ZERO)
      |=> (pin_active_o.dac && pin_clk_o.dac == $past(pin_zero)))
    else $error("DAC pin zero not routed");
  AST_DAC_PIN_TWO: assert property (
    (dac_src_sel_i == `GCS_SRC_PIN_DSP_DAC && sel_dsp_dac_ff[`GCS_FLD_LO] == `GCS_CODE_PIN_TWO)
      |=> (pin_active_o.dac && pin_clk_o.dac == $past(pin_two)))
    else $error("DAC pin two not routed");
  AST_CP_PIN_TWO: assert property (
    (cp_src_sel_i == `GCS_SRC_PIN_CP_OSR && sel_cp_osr_ff[`GCS_FLD_HI] == `GCS_CODE_PIN_TWO)
      |=> (pin_active_o.cp && pin_clk_o.cp == $past(pin_two)))
    else $error("Charge-pump pin two not routed");
  AST_CP_RESERVED_MUTE: assert property (
    (sel_cp_osr_ff[`GCS_FLD_HI] == `GCS_CODE_RESERVED) |=> (!pin_active_o.cp && !pin_clk_o.cp))
    else $error("Charge-pump reserved code not muted");
  AST_OSR_ROUTE: assert property (
    (osr_src_sel_i == `GCS_SRC_PIN_CP_OSR && sel_cp_osr_ff[`GCS_FLD_LO] == `GCS_CODE_PIN_ZERO)
      |=> (pin_active_o.osr && pin_clk_o.osr == $past(pin_zero)))
    else $error("Oversampling pin zero not routed");
  AST_OSR_RESERVED_MUTE: assert property (
    (sel_cp_osr_ff[`GCS_FLD_LO] == `GCS_CODE_RESERVED) |=> (!pin_active_o.osr && !pin_clk_o.osr))
    else $error("Oversampling reserved code not muted");
  AST_REF_PIN_ZERO: assert property (
    (pll_ref_source_sel_i == `GCS_SRC_PIN_PLL_REF && sel_ref_ff[`GCS_FLD_LO] == `GCS_CODE_PIN_ZERO)
      |=> (pin_active_o.pll_ref && pin_clk_o.pll_ref == $past(pin_zero)))
    else $error("PLL reference pin zero not routed");
  AST_REF_MUTE: assert property (
    (sel_ref_ff[`GCS_FLD_LO] != `GCS_CODE_PIN_ZERO && sel_ref_ff[`GCS_FLD_LO] != `GCS_CODE_PIN_TWO)
      |=> (!pin_active_o.pll_ref && !pin_clk_o.pll_ref))
    else $error("PLL reference not muted");
  AST_REF_SOURCE_GATE: assert property (
    (pll_ref_source_sel_i != `GCS_SRC_PIN_PLL_REF) |=> !pin_active_o.pll_ref)
    else $error("PLL reference pin path used without pin source");

  // Factor checks other than AST_AUTO_OVERRIDE need auto mode low on the cycle that feeds the output register
  AST_PRE_DIV: assert property (
    (!auto_clk_set_i ##1 !auto_clk_set_i)
      |=> (pll_cfg_o.pre_div == `GCS_ONE_5B + {1'b0, $past(pre_div_ff[`GCS_FLD_PRE_DIV])}))
    else $error("Pre-divider decode wrong");
  AST_INT_MULT_WRITE: assert property (
    (reg_req_i.wr && reg_req_i.addr == `GCS_ADDR_INT_MULT && !auto_clk_set_i) ##1 !auto_clk_set_i
      |=> (pll_cfg_o.int_mult == $past(reg_req_i.wdata[`GCS_FLD_INT_MULT], 2)))
    else $error("Integer multiplier not applied");
  AST_AUTO_OVERRIDE: assert property (
    auto_clk_set_i |=> (pll_cfg_o.pre_div == `GCS_ONE_5B + {1'b0, `GCS_AUTO_PRE_DIV} &&
      pll_cfg_o.int_mult == `GCS_AUTO_INT_MULT && pll_cfg_o.r_mult == `GCS_ONE_5B + {1'b0, `GCS_AUTO_R_MULT}))
    else $error("Auto mode did not override P, J and R");
  AST_R_DECODE: assert property (
    !auto_clk_set_i |=> (pll_cfg_o.r_mult == `GCS_ONE_5B + {1'b0, $past(pll_r_mult_i)}))
    else $error("R decode wrong");
  AST_TOTAL: assert property (
    !auto_clk_set_i |=> (pll_cfg_o.mult_total ==
      11'($past(int_mult_ff[`GCS_FLD_INT_MULT])) * 11'(`GCS_ONE_5B + {1'b0, $past(pll_r_mult_i)})))
    else $error("Multiplication total wrong");

  COV_DSP_PIN_TWO: cover property (pin_active_o.dsp && sel_dsp_dac_ff[`GCS_FLD_HI] == `GCS_CODE_PIN_TWO);
  COV_REF_PIN: cover property (pin_active_o.pll_ref);
  COV_OSR_PIN_HIGH: cover property (pin_active_o.osr && pin_clk_o.osr);
  COV_AUTO_LEAVE: cover property (auto_clk_set_i ##1 !auto_clk_set_i);
endmodule

// ===== dv/gcs_top_tb.sv
// Purpose: Self-checking bench for pin clock routing and PLL factor registers.
// Assumes: Pins are held steady while the routed outputs settle.
// Notes: Expected values come from a register and route model kept here.
`timescale 1ns/1ps
module gcs_top_tb;
  import gcs_pkg::*;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  gcs_reg_req_t reg_req_i = '0;
  logic [7:0] reg_rd_addr_i = 8'h00;
  logic [2:0] dsp_src_sel_i = 3'h0;
  logic [2:0] dac_src_sel_i = 3'h0;
  logic [2:0] cp_src_sel_i = 3'h0;
  logic [2:0] osr_src_sel_i = 3'h0;
  logic [2:0] pll_ref_source_sel_i = 3'h0;
  logic [3:0] pll_r_mult_i = 4'h0;
  logic auto_clk_set_i = 1'b0;
  logic general_pin_zero_i = 1'b0;
  logic general_pin_two_i = 1'b0;
  logic [7:0] reg_rdata_o;
  gcs_route_t pin_clk_o;
  gcs_route_t pin_active_o;
  gcs_pll_t pll_cfg_o;
  int num_errors = 0;
  int n_checks = 0;
  int cycles = 0;
  int seed = 32'h6D8F6731;
  logic [7:0] mdl [0:255];
  logic [7:0] addrs [0:7] = '{8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h15, 8'h16, 8'hFF};
  gcs_reg_req_t w;
  gcs_pll_t e;
  logic [7:0] a, d;
  logic [3:0] p;
  logic [5:0] j;
  logic [9:0] ea, ec;
  ////////////////////////////////////////////////////////////////////////////
  gcs_top DUT (.clk_i(clk_i), .reset_i(reset_i), .reg_req_i(reg_req_i), .reg_rd_addr_i(reg_rd_addr_i),
    .reg_rdata_o(reg_rdata_o), .dsp_src_sel_i(dsp_src_sel_i), .dac_src_sel_i(dac_src_sel_i),
    .cp_src_sel_i(cp_src_sel_i), .osr_src_sel_i(osr_src_sel_i), .pll_ref_source_sel_i(pll_ref_source_sel_i),
    .pll_r_mult_i(pll_r_mult_i), .auto_clk_set_i(auto_clk_set_i), .general_pin_zero_i(general_pin_zero_i),
    .general_pin_two_i(general_pin_two_i), .pin_clk_o(pin_clk_o), .pin_active_o(pin_active_o),
    .pll_cfg_o(pll_cfg_o));
  always #5 clk_i = ~clk_i;
  // Guards against a stuck wait: ends the run as a failure after 5000 cycles
  always @(posedge clk_i) begin
    cycles++;
    if (cycles > 5000) begin
      num_errors++;
      summarize();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic [7:0] msk(input logic [7:0] ad);
    case (ad)
      8'h10, 8'h11: return 8'h77;
      8'h12: return 8'h07;
      8'h14: return 8'h0F;
      8'h15: return 8'h3F;
      default: return 8'h00;
    endcase
  endfunction
  task automatic wr(input logic [7:0] ad, input logic [7:0] dt);
    @(posedge clk_i) reg_req_i <= '{wr: 1'b1, addr: ad, wdata: dt};
    @(posedge clk_i) reg_req_i.wr <= 1'b0;
    mdl[ad] = dt & msk(ad);
  endtask
  task automatic rd_chk(input logic [7:0] ad);
    @(posedge clk_i) reg_rd_addr_i <= ad;
    repeat (2) @(posedge clk_i);
    #1 chk(reg_rdata_o, mdl[ad]);
  endtask
  // Pin path live only for a pin source code and selector code 011 or 101
  function automatic logic [1:0] rt(input logic [2:0] s, input logic [2:0] ps, input logic [2:0] c);
    logic act;
    act = (s == ps) && (c == 3'h3 || c == 3'h5);
    return {act, act && (c == 3'h3 ? general_pin_zero_i : general_pin_two_i)};
  endfunction
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    for (int i = 0; i < 256; i++) mdl[i] = 8'h00;
    mdl[8'h15] = 8'h08;
    repeat (20) @(posedge clk_i);
    reset_i <= 1'b0;
    for (int i = 0; i < 8; i++) rd_chk(addrs[i]);
    $display("test reset values done");
    for (int i = 0; i < 24; i++) begin
      a = addrs[$unsigned($random(seed)) % 8];
      d = 8'($random(seed));
      if (a == 8'h14 && d[3:0] == 4'hF) d[3:0] = 4'hE;
      if (a == 8'h15 && d[5:0] == 6'h00) d[0] = 1'b1;
      wr(a, d);
      rd_chk(addrs[$unsigned($random(seed)) % 8]);
    end
    $display("test register access done");
    for (int i = 0; i < 16; i++) begin
      wr(8'h10, {1'b0, i[2:0], 1'b0, i[2:0]});
      wr(8'h11, {1'b0, i[2:0], 1'b0, i[2:0]});
      wr(8'h12, {5'h00, i[2:0]});
      @(posedge clk_i) begin
        dsp_src_sel_i <= i[3] ? 3'($random(seed)) : 3'h5;
        dac_src_sel_i <= 3'h5;
        cp_src_sel_i <= i[3] ? 3'($random(seed)) : 3'h6;
        osr_src_sel_i <= 3'h6;
        pll_ref_source_sel_i <= i[3] ? 3'($random(seed)) : 3'h3;
        // Pins always opposite, so a swapped route shows; each level is seen on each code
        general_pin_zero_i <= ~(i[0] ^ i[3]);
        general_pin_two_i <= i[0] ^ i[3];
      end
      repeat (8) @(posedge clk_i);
      #1;
      {ea[9], ec[9]} = rt(dsp_src_sel_i, 3'h5, i[2:0]);
      {ea[8], ec[8]} = rt(dac_src_sel_i, 3'h5, i[2:0]);
      {ea[7], ec[7]} = rt(cp_src_sel_i, 3'h6, i[2:0]);
      {ea[6], ec[6]} = rt(osr_src_sel_i, 3'h6, i[2:0]);
      {ea[5], ec[5]} = rt(pll_ref_source_sel_i, 3'h3, i[2:0]);
      chk(pin_active_o, ea[9:5]);
      chk(pin_clk_o, ec[9:5]);
    end
    $display("test pin routing done");
    for (int i = 0; i < 20; i++) begin
      p = (i == 0) ? 4'h0 : (i == 1) ? 4'hE : 4'($unsigned($random(seed)) % 15);
      j = (i == 0) ? 6'h01 : (i == 1) ? 6'h3F : 6'($unsigned($random(seed)) % 63 + 1);
      wr(8'h14, {4'h0, p});
      wr(8'h15, {2'h0, j});
      @(posedge clk_i) begin
        pll_r_mult_i <= (i == 2) ? 4'hF : 4'($random(seed));
        auto_clk_set_i <= (i % 4 == 3);
      end
      repeat (3) @(posedge clk_i);
      #1;
      e.pre_div = auto_clk_set_i ? 5'h01 : 5'(p) + 5'h01;
      e.int_mult = auto_clk_set_i ? 6'h08 : j;
      e.r_mult = auto_clk_set_i ? 5'h01 : 5'(pll_r_mult_i) + 5'h01;
      e.mult_total = 11'(e.int_mult) * 11'(e.r_mult);
      chk(pll_cfg_o, e);
    end
    $display("test pll factors done");
    summarize();
  end
endmodule
